// ---- hdl/osc_one_shot.sv ----
// one-shot trigger, prescaled down counter and output control
`timescale 1ns/1ps
`default_nettype none
module osc_one_shot #(
    parameter int CNT_W = 8
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // selected count source, one-cycle tick per source cycle
    input wire logic cnt_src_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [osc_pkg::OSC_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pins
    input wire logic ext_trigger_pin_i,
    output logic pulse_output_pin_o,
    output logic timer_irq_o
);
    import osc_pkg::*;

    logic rst_m_q;
    logic rst_n_q;
    logic [3:0] io_q;
    logic count_start_bit_q;
    logic count_status_flag_q;
    logic one_shot_active_flag_q;
    logic pend_q;
    logic [CNT_W-1:0] pre_rel_q;
    logic [CNT_W-1:0] per_rel_q;
    logic [CNT_W-1:0] pre_cnt_q;
    logic [CNT_W-1:0] per_cnt_q;
    logic irq_request_flag_q;
    logic irq_edge_polarity_q;
    logic both_edge_select_q;
    logic pin_irq_enable_q;
    logic out_q;
    logic tirq_q;
    logic end_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic pin_lvl;
    logic pin_rise;
    logic pin_fall;
    logic req;
    logic wr;
    logic wr_lane;
    logic sw_trig;
    logic pin_trig;
    logic trig;
    logic stop_req;
    logic underflow;
    logic pin_irq_evt;
    logic irq_clr;

    function automatic logic hit(input logic [7:0] adr,
                                 input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction

    // reset released through two flops
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_m_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n_q <= rst_m_q;
        end
    end

    osc_edge_sync u_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_q),
        .ce_i(ce_i),
        .pin_i(ext_trigger_pin_i),
        .level_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = req & wb_we_i;
    assign wr_lane = wr & wb_sel_i[0];

    // software start command, one cycle
    assign sw_trig = wr_lane & hit(wb_adr_i, OSC_OS_CTRL_OFS) &
                     wb_dat_i[OSC_OSST_BIT];
    assign pin_trig = io_q[OSC_PTE_BIT] &
                      (io_q[OSC_PES_BIT] ? pin_rise : pin_fall);
    assign trig = sw_trig | pin_trig;

    // any of the three stop causes
    assign stop_req = wr_lane & (
        (hit(wb_adr_i, OSC_OS_CTRL_OFS) & wb_dat_i[OSC_OSSP_BIT]) |
        (hit(wb_adr_i, OSC_TMR_CTRL_OFS) &
         (wb_dat_i[OSC_FSTOP_BIT] | ~wb_dat_i[OSC_START_BIT])));

    assign underflow = one_shot_active_flag_q & cnt_src_i &
                       (pre_cnt_q == '0) & (per_cnt_q == '0);

    // pin interrupt edge uses its own polarity, not the trigger edge
    assign pin_irq_evt = pin_irq_enable_q & (both_edge_select_q ?
        (pin_rise | pin_fall) :
        (irq_edge_polarity_q ? pin_rise : pin_fall));
    assign irq_clr = wr_lane & hit(wb_adr_i, OSC_PIN_IRQ_OFS) &
                     ~wb_dat_i[OSC_IRQF_BIT];

    // bus handshake: ack one cycle after the request, then dropped
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            dat_q <= OSC_UNMAPPED_DATA;
        end else if (ce_i) begin
            ack_q <= req;
            if (req) begin
                dat_q <= OSC_UNMAPPED_DATA;
                case (wb_adr_i)
                    OSC_IO_CTRL_OFS: dat_q[3:0] <= io_q;
                    OSC_TMR_CTRL_OFS: begin
                        dat_q[OSC_START_BIT] <= count_start_bit_q;
                        dat_q[OSC_CSF_BIT] <= count_status_flag_q;
                    end
                    OSC_OS_CTRL_OFS:
                        dat_q[OSC_ACT_BIT] <= one_shot_active_flag_q;
                    OSC_PRESCALE_OFS: dat_q[CNT_W-1:0] <= pre_cnt_q;
                    OSC_PERIOD_OFS: dat_q[CNT_W-1:0] <= per_cnt_q;
                    OSC_PIN_IRQ_OFS: begin
                        dat_q[OSC_IRQF_BIT] <= irq_request_flag_q;
                        dat_q[OSC_POL_BIT] <= irq_edge_polarity_q;
                        dat_q[OSC_BOTH_BIT] <= both_edge_select_q;
                        dat_q[OSC_IEN_BIT] <= pin_irq_enable_q;
                    end
                    default: dat_q <= OSC_UNMAPPED_DATA;
                endcase
            end
        end
    end

    // io control and pin interrupt configuration
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            io_q <= OSC_IO_RST[3:0];
            irq_edge_polarity_q <= 1'b0;
            both_edge_select_q <= 1'b0;
            pin_irq_enable_q <= 1'b0;
        end else if (ce_i && wr_lane) begin
            if (hit(wb_adr_i, OSC_IO_CTRL_OFS))
                io_q <= wb_dat_i[3:0] & OSC_IO_MASK;
            if (hit(wb_adr_i, OSC_PIN_IRQ_OFS)) begin
                irq_edge_polarity_q <= wb_dat_i[OSC_POL_BIT];
                both_edge_select_q <= wb_dat_i[OSC_BOTH_BIT];
                pin_irq_enable_q <= wb_dat_i[OSC_IEN_BIT];
            end
        end
    end

    // pin interrupt request flag: a new edge wins over a clear
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_request_flag_q <= 1'b0;
        end else if (ce_i) begin
            if (pin_irq_evt)
                irq_request_flag_q <= 1'b1;
            else if (irq_clr)
                irq_request_flag_q <= 1'b0;
        end
    end

    // start bit and its status copy, which sets on a count tick while started and clears on the clock after the start bit clears
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_start_bit_q <= 1'b0;
            count_status_flag_q <= 1'b0;
        end else if (ce_i) begin
            if (wr_lane && hit(wb_adr_i, OSC_TMR_CTRL_OFS))
                count_start_bit_q <= wb_dat_i[OSC_START_BIT] &
                                     ~wb_dat_i[OSC_FSTOP_BIT];
            if (!count_start_bit_q)
                count_status_flag_q <= 1'b0;
            else if (cnt_src_i)
                count_status_flag_q <= 1'b1;
        end
    end

    // trigger latch: taken only when counting and not already running
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pend_q <= 1'b0;
        end else if (ce_i) begin
            if (stop_req || one_shot_active_flag_q)
                pend_q <= 1'b0;
            else if (trig && count_status_flag_q)
                pend_q <= 1'b1;
            else if (cnt_src_i)
                pend_q <= 1'b0;
        end
    end

    // one-shot counter; reload values land in the counter while idle, on stop and at underflow; only the prescale reload lands at each prescaler wrap
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pre_rel_q <= OSC_PRESCALE_RST[CNT_W-1:0];
            per_rel_q <= OSC_PERIOD_RST[CNT_W-1:0];
            pre_cnt_q <= OSC_PRESCALE_RST[CNT_W-1:0];
            per_cnt_q <= OSC_PERIOD_RST[CNT_W-1:0];
            one_shot_active_flag_q <= 1'b0;
            end_q <= 1'b0;
            tirq_q <= 1'b0;
        end else if (ce_i) begin
            // irq waits one clock so it meets the output's return to idle
            end_q <= 1'b0;
            tirq_q <= end_q;
            if (wr_lane && hit(wb_adr_i, OSC_PRESCALE_OFS))
                pre_rel_q <= wb_dat_i[CNT_W-1:0];
            if (wr_lane && hit(wb_adr_i, OSC_PERIOD_OFS))
                per_rel_q <= wb_dat_i[CNT_W-1:0];
            if (stop_req) begin
                one_shot_active_flag_q <= 1'b0;
                pre_cnt_q <= pre_rel_q;
                per_cnt_q <= per_rel_q;
            end else if (!one_shot_active_flag_q) begin
                // tick after the trigger: one to two source cycles
                if (pend_q && cnt_src_i && count_status_flag_q)
                    one_shot_active_flag_q <= 1'b1;
                if (wr_lane && hit(wb_adr_i, OSC_PRESCALE_OFS))
                    pre_cnt_q <= wb_dat_i[CNT_W-1:0];
                else
                    pre_cnt_q <= pre_rel_q;
                if (wr_lane && hit(wb_adr_i, OSC_PERIOD_OFS))
                    per_cnt_q <= wb_dat_i[CNT_W-1:0];
                else
                    per_cnt_q <= per_rel_q;
            end else if (underflow) begin
                one_shot_active_flag_q <= 1'b0;
                pre_cnt_q <= pre_rel_q;
                per_cnt_q <= per_rel_q;
                end_q <= 1'b1;
            end else if (cnt_src_i) begin
                if (pre_cnt_q == '0) begin
                    pre_cnt_q <= pre_rel_q;
                    per_cnt_q <= per_cnt_q - 1'b1;
                end else begin
                    pre_cnt_q <= pre_cnt_q - 1'b1;
                end
            end
        end
    end

    // output follows the active flag one clock later, inverted by level
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_q <= 1'b0;
        end else if (ce_i) begin
            out_q <= one_shot_active_flag_q ^ io_q[OSC_LVL_BIT];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign pulse_output_pin_o = out_q;
    assign timer_irq_o = tirq_q;

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_q);

    a_reserved_zero: assert property (
        ack_q && $past(wb_adr_i) == OSC_IO_CTRL_OFS |-> dat_q[31:4] == '0)
        else $error("io control upper bits not zero");

    a_out_level: assert property (
        ce_i |=> out_q == $past(one_shot_active_flag_q ^ io_q[OSC_LVL_BIT]))
        else $error("pulse output level wrong");

    a_start_needs_csf: assert property (
        $rose(pend_q) |-> $past(count_status_flag_q && trig))
        else $error("trigger accepted while not counting");

    a_active_after_tick: assert property (
        $rose(one_shot_active_flag_q) |->
            $past(pend_q && cnt_src_i && ce_i))
        else $error("active flag set without pending trigger");

    a_retrig_ignored: assert property (
        ce_i && one_shot_active_flag_q && trig |=> !pend_q)
        else $error("retrigger accepted while active");

    a_pin_irq_kept: assert property (
        ce_i && pin_irq_evt |=> irq_request_flag_q)
        else $error("pin edge lost from irq flag");

    a_irq_at_end: assert property (
        $rose(tirq_q) |-> $changed(out_q) && out_q == io_q[OSC_LVL_BIT])
        else $error("timer irq not at pulse end");

    a_stop_halts: assert property (
        ce_i && stop_req |=> !one_shot_active_flag_q &&
            per_cnt_q == $past(per_rel_q))
        else $error("stop did not halt and reload");

    a_reload_under: assert property (
        ce_i && underflow && !stop_req |=> pre_cnt_q == $past(pre_rel_q)
            && per_cnt_q == $past(per_rel_q))
        else $error("counter not reloaded at underflow");

    a_active_needs_csf: assert property (
        $rose(one_shot_active_flag_q) |-> $past(count_status_flag_q))
        else $error("one-shot started while not counting");

    a_csf_follows: assert property (
        ce_i && !count_start_bit_q |=> !count_status_flag_q)
        else $error("status flag set while start bit clear");

    a_stop_drops_pend: assert property (
        ce_i && stop_req |=> !pend_q)
        else $error("trigger kept across a stop");

    a_irq_single: assert property (
        ce_i && tirq_q |=> !tirq_q)
        else $error("timer irq longer than one clock");

    c_pin_start: cover property (
        pin_trig && count_status_flag_q ##[1:20] one_shot_active_flag_q);
    c_full_pulse: cover property (
        $rose(one_shot_active_flag_q) ##[1:600] tirq_q);
    c_retrigger: cover property (one_shot_active_flag_q && trig);
    c_irq_clear_race: cover property (pin_irq_evt && irq_clr);
endmodule
`default_nettype wire

// ---- hdl/osc_pkg.sv ----
// constants and register map of the one-shot trigger and output block
// What this block does
// - level select sets active and idle output levels
// - edge select picks falling or rising pin trigger
// - io control bits 4 to 7 read zero
// - trigger starts one-shot only while counting enabled
// - software start or pin edge both trigger
// - active flag sets one or two ticks after trigger
// - active flag starts counting and pulse output
// - triggers ignored while one-shot is active
// - trigger edge select never affects pin interrupt
// - pin edge during one-shot still sets irq flag
// - pulse lasts (prescale+1)(period+1) count ticks
// - timer interrupt coincides with pulse end
// - stop, start clear or forced stop halt and reload
package osc_pkg;

    localparam int OSC_ADR_W = 8;
    localparam int OSC_REG_W = 8;

    // register byte addresses
    localparam logic [7:0] OSC_IO_CTRL_OFS = 8'h00;
    localparam logic [7:0] OSC_TMR_CTRL_OFS = 8'h04;
    localparam logic [7:0] OSC_OS_CTRL_OFS = 8'h08;
    localparam logic [7:0] OSC_PRESCALE_OFS = 8'h0c;
    localparam logic [7:0] OSC_PERIOD_OFS = 8'h10;
    localparam logic [7:0] OSC_PIN_IRQ_OFS = 8'h14;

    // one_shot_io_control fields
    localparam int OSC_LVL_BIT = 0;
    localparam int OSC_CNT_BIT = 1;
    localparam int OSC_PTE_BIT = 2;
    localparam int OSC_PES_BIT = 3;
    localparam logic [3:0] OSC_IO_MASK = 4'hf;

    // timer_control_reg fields
    localparam int OSC_START_BIT = 0;
    localparam int OSC_CSF_BIT = 1;
    localparam int OSC_FSTOP_BIT = 2;

    // one_shot_control_reg fields
    localparam int OSC_OSST_BIT = 0;
    localparam int OSC_OSSP_BIT = 1;
    localparam int OSC_ACT_BIT = 2;

    // pin_irq_control_reg fields
    localparam int OSC_IRQF_BIT = 0;
    localparam int OSC_POL_BIT = 1;
    localparam int OSC_BOTH_BIT = 2;
    localparam int OSC_IEN_BIT = 3;

    // values after reset
    localparam logic [7:0] OSC_IO_RST = 8'h00;
    localparam logic [7:0] OSC_PRESCALE_RST = 8'h00;
    localparam logic [7:0] OSC_PERIOD_RST = 8'h00;
    localparam logic [31:0] OSC_UNMAPPED_DATA = 32'h0000_0000;

endpackage

// ---- hdl/osc_edge_sync.sv ----
// two-flop synchroniser with edge detection for the trigger pin
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sync (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // pin side
    input wire logic pin_i,
    // synchronised side
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // meta_q is read only by sync_q
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (ce_i) begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ---- tb/osc_trig_src.sv ----
// trigger source model driving the external trigger pin
`timescale 1ns/1ps
`default_nettype none
module osc_trig_src (
    // clock
    input wire logic mclk_i,
    // bench command
    input wire logic fire_i,
    input wire logic [7:0] hold_i,
    // pin
    output logic pin_o
);
    logic [7:0] cnt_q = 8'h00;

    // low phase lasts hold_i clocks, long enough for the pin synchroniser
    always_ff @(posedge mclk_i) begin
        if (fire_i && cnt_q == 8'h00) begin
            cnt_q <= hold_i;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // pin is pulled up, so it idles high between triggers
    assign pin_o = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// ---- tb/one_shot_trigger_output_control_tb_top.sv ----
// self-checking bench for the one-shot trigger and output block
`timescale 1ns/1ps
`default_nettype none
module one_shot_trigger_output_control_tb_top;
    import osc_pkg::*;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic pin;
    logic pulse;
    logic irq;
    logic fire = 1'b0;
    logic [7:0] hold = 8'h00;
    logic idle = 1'b0;
    logic [31:0] q;
    logic [3:0] sel = 4'h0;
    logic [3:0] lanes = 4'hf;
    logic ce = 1'b1;
    logic tick = 1'b1;
    logic slow = 1'b0;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int dly;
    int wid;
    int nirq;
    int eirq;

    always #25 mclk_i = ~mclk_i;

    // count source ticks every clock unless slow, so widths read in clocks
    always @(posedge mclk_i) begin
        tick <= slow ? ~tick : 1'b1;
    end

    osc_one_shot #(.CNT_W(8)) i_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce), .cnt_src_i(tick),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_trigger_pin_i(pin), .pulse_output_pin_o(pulse),
        .timer_irq_o(irq));

    osc_trig_src i_src (.mclk_i(mclk_i), .fire_i(fire), .hold_i(hold),
        .pin_o(pin));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        sel <= lanes;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(n, q, e);
    endtask

    // samples just after each edge, so counts are whole clock cycles
    task automatic shot(input int lim);
        dly = 0;
        wid = 0;
        nirq = 0;
        while (pulse === idle && dly < lim) begin
            @(posedge mclk_i);
            dly++;
        end
        while (pulse !== idle && wid < 300) begin
            nirq += (irq === 1'b1) ? 1 : 0;
            @(posedge mclk_i);
            wid++;
        end
        // first idle sample: the timer irq must stand here
        eirq = (irq === 1'b1) ? 1 : 0;
    endtask

    task automatic fire_pin(input logic [7:0] h);
        @(posedge mclk_i);
        hold <= h;
        fire <= 1'b1;
        @(posedge mclk_i);
        fire <= 1'b0;
    endtask

    task automatic drain();
        while (pulse !== idle) @(posedge mclk_i);
        shot(40);
    endtask

    task automatic t_regs();
        check("pulse idle", 32'(pulse), 32'h0);
        rchk("io reset", OSC_IO_CTRL_OFS, 32'h0);
        bus(1'b1, OSC_IO_CTRL_OFS, 32'hf2);
        rchk("io upper bits", OSC_IO_CTRL_OFS, 32'h02);
        rchk("unmapped", 8'h3c, 32'h0);
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h00);
        lanes = 4'he;
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h02);
        lanes = 4'hf;
        rchk("lane off", OSC_IO_CTRL_OFS, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_soft();
        bus(1'b1, OSC_PRESCALE_OFS, 32'h03);
        bus(1'b1, OSC_PERIOD_OFS, 32'h03);
        bus(1'b1, OSC_TMR_CTRL_OFS, 32'h01);
        rchk("status flag", OSC_TMR_CTRL_OFS, 32'h03);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        shot(20);
        check("width", 32'(wid), 32'd16);
        check("irq in pulse", 32'(nirq), 32'd0);
        check("irq at end", 32'(eirq), 32'h1);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        drain();
        check("no restart", 32'(wid), 32'd0);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h02);
        repeat (3) @(posedge mclk_i);
        check("stopped", 32'(pulse), 32'h0);
        rchk("reloaded", OSC_PRESCALE_OFS, 32'h03);
        bus(1'b1, OSC_TMR_CTRL_OFS, 32'h00);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        shot(30);
        check("count off", 32'(wid), 32'd0);
        bus(1'b1, OSC_TMR_CTRL_OFS, 32'h01);
        $display("test soft done");
    endtask

    task automatic t_level();
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h01);
        repeat (3) @(posedge mclk_i);
        idle = 1'b1;
        check("idle high", 32'(pulse), 32'h1);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        shot(20);
        check("low width", 32'(wid), 32'd16);
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h00);
        repeat (3) @(posedge mclk_i);
        idle = 1'b0;
        $display("test level done");
    endtask

    // clock enable low must freeze a running one-shot
    task automatic t_freeze();
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        ce <= 1'b0;
        repeat (20) @(posedge mclk_i);
        check("frozen", 32'(pulse), 32'h0);
        ce <= 1'b1;
        shot(20);
        check("freeze width", 32'(wid), 32'd16);
        $display("test freeze done");
    endtask

    // count source at half the clock: width doubles in clocks
    task automatic t_slow();
        slow <= 1'b1;
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        shot(20);
        check("slow width", 32'(wid), 32'd32);
        check("slow irq", 32'(eirq), 32'h1);
        slow <= 1'b0;
        $display("test slow done");
    endtask

    task automatic t_pin();
        // pin interrupt set up first, trigger enable last
        bus(1'b1, OSC_PIN_IRQ_OFS, 32'h0a);
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h04);
        fire_pin(8'd40);
        shot(40);
        check("fall delay", 32'(dly < 12), 32'h1);
        check("pin width", 32'(wid), 32'd16);
        rchk("flag after fall", OSC_PIN_IRQ_OFS, 32'h0a);
        repeat (40) @(posedge mclk_i);
        rchk("flag after rise", OSC_PIN_IRQ_OFS, 32'h0b);
        bus(1'b1, OSC_PIN_IRQ_OFS, 32'h0a);
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h0c);
        fire_pin(8'd30);
        shot(60);
        check("rise delay", 32'(dly > 30), 32'h1);
        check("rise width", 32'(wid), 32'd16);
        bus(1'b1, OSC_PIN_IRQ_OFS, 32'h0a);
        bus(1'b1, OSC_OS_CTRL_OFS, 32'h01);
        fire_pin(8'd3);
        drain();
        check("pin retrigger", 32'(wid), 32'd0);
        rchk("flag in shot", OSC_PIN_IRQ_OFS, 32'h0b);
        // both edges flag the irq; trigger disabled, so no pulse
        bus(1'b1, OSC_PIN_IRQ_OFS, 32'h0c);
        bus(1'b1, OSC_IO_CTRL_OFS, 32'h00);
        fire_pin(8'd40);
        repeat (10) @(posedge mclk_i);
        rchk("both fall", OSC_PIN_IRQ_OFS, 32'h0d);
        bus(1'b1, OSC_PIN_IRQ_OFS, 32'h0c);
        shot(40);
        check("pin disabled", 32'(wid), 32'd0);
        rchk("both rise", OSC_PIN_IRQ_OFS, 32'h0d);
        $display("test pin done");
    endtask

    initial begin
        repeat (20) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        t_regs();
        t_soft();
        t_level();
        t_freeze();
        t_slow();
        t_pin();
        end_sim();
    end
endmodule
`default_nettype wire
